// ==== cnc_node_cfg.sv ====
// Node configuration from rotary switches or object entries, boot-up request and indicators.
// Switch pins are asynchronous; status and object access come from logic on CLK_SYS.
// One indicator tick lasts TICK_CYCLES clocks; simulation may shorten it.
`timescale 1ns/1ps

module cnc_node_cfg #(
	parameter int TICK_CYCLES = cnc_pkg::TICK_CYCLES
) (
	input  wire logic                     CLK_SYS,
	input  wire logic                     SYS_RST,
	input  wire logic [3:0]               UNITS_ADDRESS_SWITCH,
	input  wire logic [3:0]               TENS_ADDRESS_SWITCH,
	input  wire logic [3:0]               BITRATE_SELECTOR_SWITCH,
	input  wire cnc_pkg::cnc_net_status_t NET_STATUS,
	input  wire cnc_pkg::cnc_od_req_t     OD_REQ,
	output cnc_pkg::cnc_od_rsp_t          OD_RSP,
	output logic [6:0]                    NODE_ID,
	output logic [2:0]                    BITRATE_CODE,
	output logic [10:0]                   BITRATE_KBPS,
	output cnc_pkg::cnc_proto_t           PROTO_MODE,
	output logic                          CONFIG_ERROR,
	output logic                          SOFTWARE_CONFIG,
	output logic                          BOOTUP_REQ,
	output logic [10:0]                   BOOTUP_COB_ID,
	output logic                          RUN_INDICATOR,
	output logic                          ERROR_INDICATOR
);

	typedef struct packed {
		// Two-stage synchronisers for the switch pins
		logic [3:0]                  units_s1;
		logic [3:0]                  units_s2;
		logic [3:0]                  tens_s1;
		logic [3:0]                  tens_s2;
		logic [3:0]                  br_s1;
		logic [3:0]                  br_s2;
		// Object entries, loaded with their defaults at reset
		logic [7:0]                  node_setting;
		logic [7:0]                  bitrate_setting;
		// Indicator timebase and pattern engines
		logic [cnc_pkg::TICK_W-1:0]  tick_cnt;
		cnc_pkg::cnc_pat_t           run_pat;
		cnc_pkg::cnc_pat_t           err_pat;
		logic [cnc_pkg::POS_W-1:0]   run_pos;
		logic [cnc_pkg::POS_W-1:0]   err_pos;
		// Boot-up sequencing
		logic [1:0]                  settle;
		logic                        booted;
		// Registered outputs
		cnc_pkg::cnc_od_rsp_t        od_rsp;
		logic [6:0]                  node_id;
		logic [2:0]                  bitrate_code;
		logic [10:0]                 bitrate_kbps;
		cnc_pkg::cnc_proto_t         proto;
		logic                        cfg_err;
		logic                        sw_cfg;
		logic                        bootup_req;
		logic [10:0]                 bootup_cob;
		logic                        run_led;
		logic                        error_indicator;
	} cnc_state_t;

	// Tick length in clocks and pattern geometry in ticks, cut to the widths of their counters
	localparam logic [cnc_pkg::TICK_W-1:0] TICK_LAST = cnc_pkg::TICK_W'(TICK_CYCLES - 1);
	localparam logic [cnc_pkg::POS_W-1:0]  ON_TICKS  = cnc_pkg::POS_W'(cnc_pkg::FLASH_ON_TICKS);
	localparam logic [cnc_pkg::POS_W-1:0]  SLOT      = cnc_pkg::POS_W'(cnc_pkg::FLASH_SLOT_TICKS);
	localparam logic [cnc_pkg::POS_W-1:0]  TAIL      = cnc_pkg::POS_W'(cnc_pkg::FLASH_TAIL_TICKS);
	localparam logic [cnc_pkg::POS_W-1:0]  GAP       = SLOT - ON_TICKS;
	localparam logic [cnc_pkg::POS_W-1:0]  STEADY    = cnc_pkg::POS_W'(cnc_pkg::STEADY_TICKS);
	localparam logic [cnc_pkg::POS_W-1:0]  FLICKER   = cnc_pkg::POS_W'(cnc_pkg::FLICKER_TICKS);
	localparam logic [cnc_pkg::POS_W-1:0]  ONE_STEP  = cnc_pkg::POS_W'(1);

	cnc_state_t       st;
	cnc_state_t       next_st;

	// Decode intermediates, all written by the one combinational process
	logic [6:0]       sw_addr;
	logic             bcd_bad;
	logic             sw_mode;
	logic             use_sw;
	logic [7:0]       node8;
	logic [2:0]       br_code;
	logic             cfg_err;
	logic             tick;
	cnc_pkg::cnc_pat_t run_pat;
	cnc_pkg::cnc_pat_t err_pat;
	logic             idx_node;
	logic             idx_br;
	logic             od_hit;

	// Flash codes hold the flash count minus one in their two low bits
	function automatic logic [2:0] flash_count(input cnc_pkg::cnc_pat_t pat);
		logic [2:0] n;
		n = {1'b0, pat[1:0]} + 3'h1;
		return n;
	endfunction

	// Flash trains: n on-phases separated by gaps, then a long dark tail
	function automatic logic [cnc_pkg::POS_W-1:0] pat_period(input cnc_pkg::cnc_pat_t pat);
		logic [cnc_pkg::POS_W-1:0] p;
		p = SLOT;
		unique case (pat)
			cnc_pkg::CNC_PAT_OFF,
			cnc_pkg::CNC_PAT_ON:      p = STEADY;
			cnc_pkg::CNC_PAT_FLICKER: p = FLICKER;
			cnc_pkg::CNC_PAT_BLINK:   p = SLOT;
			cnc_pkg::CNC_PAT_FLASH1,
			cnc_pkg::CNC_PAT_FLASH2,
			cnc_pkg::CNC_PAT_FLASH3,
			cnc_pkg::CNC_PAT_FLASH4: begin
				// n slots, with the last gap stretched into the dark tail
				p = cnc_pkg::POS_W'(flash_count(pat)) * SLOT - GAP + TAIL;
			end
		endcase
		return p;
	endfunction

	// inv moves the error flicker into the even ticks, opposite the run flicker
	function automatic logic pat_level(input cnc_pkg::cnc_pat_t pat,
	                                   input logic [cnc_pkg::POS_W-1:0] pos,
	                                   input logic inv);
		logic lvl;
		lvl = 1'b0;
		unique case (pat)
			cnc_pkg::CNC_PAT_OFF:     lvl = 1'b0;
			cnc_pkg::CNC_PAT_ON:      lvl = 1'b1;
			cnc_pkg::CNC_PAT_FLICKER: lvl = pos[0] ^ inv;
			cnc_pkg::CNC_PAT_BLINK:   lvl = (pos < ON_TICKS);
			cnc_pkg::CNC_PAT_FLASH1,
			cnc_pkg::CNC_PAT_FLASH2,
			cnc_pkg::CNC_PAT_FLASH3,
			cnc_pkg::CNC_PAT_FLASH4: begin
				lvl = (pos < cnc_pkg::POS_W'(flash_count(pat)) * SLOT) && ((pos % SLOT) < ON_TICKS);
			end
		endcase
		return lvl;
	endfunction

	// A new pattern restarts at its first phase so that both flickers stay in opposition
	function automatic logic [cnc_pkg::POS_W-1:0] pos_step(input cnc_pkg::cnc_pat_t pat_new,
	                                                      input cnc_pkg::cnc_pat_t pat_old,
	                                                      input logic [cnc_pkg::POS_W-1:0] pos,
	                                                      input logic t);
		logic [cnc_pkg::POS_W-1:0] n;
		n = pos;
		if (pat_new != pat_old) begin
			n = '0;
		end else if (t) begin
			n = (pos >= pat_period(pat_old) - ONE_STEP) ? '0 : pos + ONE_STEP;
		end
		return n;
	endfunction

	always_comb begin
		next_st = st;
		// Only the second stage of each synchroniser feeds any logic
		next_st.units_s1 = UNITS_ADDRESS_SWITCH;
		next_st.units_s2 = st.units_s1;
		next_st.tens_s1  = TENS_ADDRESS_SWITCH;
		next_st.tens_s2  = st.tens_s1;
		next_st.br_s1    = BITRATE_SELECTOR_SWITCH;
		next_st.br_s2    = st.br_s1;

		// Switch decode
		// Addresses above 89 and broken digits fall back to the software node setting
		sw_addr = 7'(st.tens_s2) * cnc_pkg::BCD_TENS_WEIGHT + 7'(st.units_s2);
		bcd_bad = (st.units_s2 > cnc_pkg::BCD_DIGIT_MAX) || (st.tens_s2 > cnc_pkg::BCD_DIGIT_MAX)
		          || (st.br_s2 > cnc_pkg::BCD_DIGIT_MAX);
		sw_mode = (st.br_s2 == cnc_pkg::BR_SW_SOFTWARE);
		use_sw  = sw_mode || bcd_bad || (sw_addr > cnc_pkg::ADDR_MAX_VALID);
		node8   = use_sw ? st.node_setting + cnc_pkg::NODE_ID_OFFSET
		                 : {1'b0, sw_addr} + cnc_pkg::NODE_ID_OFFSET;
		br_code = sw_mode ? st.bitrate_setting[2:0] : st.br_s2[2:0];
		// Out-of-range settings are still used, but flagged so a bad write stays visible
		cfg_err = bcd_bad
		          || (!sw_mode && st.br_s2 == cnc_pkg::BR_SW_RESERVED)
		          || (!sw_mode && sw_addr > cnc_pkg::ADDR_MAX_VALID
		              && sw_addr < cnc_pkg::ADDR_LEGACY)
		          || (use_sw && st.node_setting > cnc_pkg::NODE_SETTING_MAX)
		          || (sw_mode && st.bitrate_setting > cnc_pkg::BR_CODE_MAX);

		// Special codes count only from a clean reading with the switches in charge
		next_st.proto = cnc_pkg::CNC_PROTO_DEFAULT;
		if (!sw_mode && !bcd_bad) begin
			if (sw_addr == cnc_pkg::ADDR_LEGACY) begin
				next_st.proto = cnc_pkg::CNC_PROTO_LEGACY;
			end else if (sw_addr == cnc_pkg::ADDR_PROTO_V3) begin
				next_st.proto = cnc_pkg::CNC_PROTO_V3;
			end else if (sw_addr == cnc_pkg::ADDR_PROTO_V4) begin
				next_st.proto = cnc_pkg::CNC_PROTO_V4;
			end
		end
		// A software setting above 126 is flagged and its low seven bits are used
		next_st.node_id      = node8[6:0];
		next_st.bitrate_code = br_code;
		next_st.bitrate_kbps = cnc_pkg::BITRATE_KBPS[br_code];
		next_st.cfg_err      = cfg_err;
		next_st.sw_cfg       = use_sw;

		// Object access; a write lands even if the same entry is read in this cycle
		// Unknown entries are answered with an error so the master never waits
		idx_node = (OD_REQ.index == cnc_pkg::OD_IDX_NODE_ID);
		idx_br   = (OD_REQ.index == cnc_pkg::OD_IDX_BITRATE);
		od_hit   = (idx_node || idx_br) && (OD_REQ.subindex == cnc_pkg::OD_SUBIDX_VALUE);
		// ack and err follow valid one clock later and stand for as long as valid is held
		next_st.od_rsp.ack   = OD_REQ.valid;
		next_st.od_rsp.err   = OD_REQ.valid && !od_hit;
		next_st.od_rsp.rdata = '0;
		if (OD_REQ.valid && od_hit) begin
			next_st.od_rsp.rdata = idx_node ? st.node_setting : st.bitrate_setting;
			if (OD_REQ.write && idx_node) begin
				next_st.node_setting = OD_REQ.wdata;
			end
			if (OD_REQ.write && idx_br) begin
				next_st.bitrate_setting = OD_REQ.wdata;
			end
		end

		// Boot-up once the synchronised switches have settled
		// The wait lets the first node number come from synchronised, decoded pins
		next_st.bootup_req = 1'b0;
		if (st.settle != cnc_pkg::SETTLE_CYCLES) begin
			next_st.settle = st.settle + 2'h1;
		end else if (!st.booted) begin
			next_st.booted     = 1'b1;
			next_st.bootup_req = 1'b1;
			next_st.bootup_cob = cnc_pkg::BOOTUP_COB_BASE + 11'(st.node_id);
		end

		// Indicator timebase
		// One shared tick keeps the two indicators in step
		tick = (st.tick_cnt >= TICK_LAST);
		next_st.tick_cnt = tick ? '0 : st.tick_cnt + cnc_pkg::TICK_W'(1);

		// Run indicator: the layer and bit-rate services override the network state
		run_pat = cnc_pkg::CNC_PAT_OFF;
		if (NET_STATUS.autobaud_lss) begin
			run_pat = cnc_pkg::CNC_PAT_FLICKER;
		end else if (NET_STATUS.fw_download) begin
			run_pat = cnc_pkg::CNC_PAT_FLASH3;
		end else begin
			unique case (NET_STATUS.nmt_state)
				cnc_pkg::CNC_NMT_INIT:    run_pat = cnc_pkg::CNC_PAT_OFF;
				cnc_pkg::CNC_NMT_PREOP:   run_pat = cnc_pkg::CNC_PAT_BLINK;
				cnc_pkg::CNC_NMT_OPER:    run_pat = cnc_pkg::CNC_PAT_ON;
				cnc_pkg::CNC_NMT_STOPPED: run_pat = cnc_pkg::CNC_PAT_FLASH1;
			endcase
		end

		// Error indicator: flicker first, then bus-off down to the configuration error
		// Most severe condition wins
		if (NET_STATUS.autobaud_lss) begin
			err_pat = cnc_pkg::CNC_PAT_FLICKER;
		end else if (NET_STATUS.bus_off) begin
			err_pat = cnc_pkg::CNC_PAT_ON;
		end else if (NET_STATUS.pdo_timeout) begin
			err_pat = cnc_pkg::CNC_PAT_FLASH4;
		end else if (NET_STATUS.sync_timeout) begin
			err_pat = cnc_pkg::CNC_PAT_FLASH3;
		end else if (NET_STATUS.guard_event) begin
			err_pat = cnc_pkg::CNC_PAT_FLASH2;
		end else if (NET_STATUS.warn_limit) begin
			err_pat = cnc_pkg::CNC_PAT_FLASH1;
		end else if (st.cfg_err) begin
			err_pat = cnc_pkg::CNC_PAT_BLINK;
		end else begin
			err_pat = cnc_pkg::CNC_PAT_OFF;
		end

		next_st.run_pat = run_pat;
		next_st.err_pat = err_pat;
		// LED levels come from the registered pattern and position, two clocks behind
		next_st.run_pos = pos_step(run_pat, st.run_pat, st.run_pos, tick);
		next_st.err_pos = pos_step(err_pat, st.err_pat, st.err_pos, tick);
		next_st.run_led = pat_level(st.run_pat, st.run_pos, 1'b0);
		next_st.error_indicator = pat_level(st.err_pat, st.err_pos, 1'b1);
	end

	// Reset reloads the object defaults, as a retained setting would after boot
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			st                 <= '0;
			st.node_setting    <= cnc_pkg::NODE_ID_RESET;
			st.bitrate_setting <= cnc_pkg::BITRATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Every output is a state register, so no decode glitch reaches a pin
	assign OD_RSP          = st.od_rsp;
	assign NODE_ID         = st.node_id;
	assign BITRATE_CODE    = st.bitrate_code;
	assign BITRATE_KBPS    = st.bitrate_kbps;
	assign PROTO_MODE      = st.proto;
	assign CONFIG_ERROR    = st.cfg_err;
	assign SOFTWARE_CONFIG = st.sw_cfg;
	assign BOOTUP_REQ      = st.bootup_req;
	assign BOOTUP_COB_ID   = st.bootup_cob;
	assign RUN_INDICATOR   = st.run_led;
	assign ERROR_INDICATOR = st.error_indicator;

endmodule

// ==== cnc_pkg.sv ====
// Constants, types and lookup tables for the node configuration and indicator block.
// Assumes a single 250 MHz system clock; switch pins are asynchronous to it.
// Notes on behaviour
// - Switch addresses 0 to 89 are node addresses; 90 to 99 are kept for special functions.
// - A switch address becomes a node number by adding one.
// - Address 97 restores legacy behaviour, 98 selects protocol v3 and 99 selects v4.
// - Bit-rate switch 0 to 7 gives 20, 50, 100, 125, 250, 500, 800, 1000 kbit/s; 8 is reserved.
// - Bit-rate switch 9 makes node number and bit rate come from the software settings.
// - Run indicator blinks in pre-operational, single-flashes stopped, triple-flashes in download, is on when operational.
// - During auto bit-rate detection or layer setting both indicators flicker in opposition.
// - Error indicator double-flashes on a guard or heartbeat event and triple-flashes on a sync timeout.
// - Error indicator quadruple-flashes on a PDO event-timer timeout and is on while bus-off.
// - The node-number setting is an 8-bit read-write object, default 1Fh, giving node 32.
// - Software settings allow node numbers 1 to 127.
// - The bit-rate setting is one read-write byte, codes 00h to 07h in switch order, default 00h.
// - After power-up the node sends a boot-up message with identifier 700h plus node number.
package cnc_pkg;

	localparam int          CLK_FREQ_HZ      = 250_000_000;
	localparam int          TICK_TIME_MS     = 50;
	localparam int          TICK_CYCLES      = TICK_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int          FLASH_ON_MS      = 200;
	localparam int          FLASH_GAP_MS     = 200;
	localparam int          FLASH_TAIL_MS    = 1000;
	localparam int          FLASH_ON_TICKS   = FLASH_ON_MS / TICK_TIME_MS;
	localparam int          FLASH_SLOT_TICKS = (FLASH_ON_MS + FLASH_GAP_MS) / TICK_TIME_MS;
	localparam int          FLASH_TAIL_TICKS = FLASH_TAIL_MS / TICK_TIME_MS;
	localparam int          STEADY_TICKS     = 1;
	localparam int          FLICKER_TICKS    = 2;
	localparam int          TICK_W           = 24;
	localparam int          POS_W            = 6;

	localparam logic [15:0] OD_IDX_NODE_ID   = 16'h3000;
	localparam logic [15:0] OD_IDX_BITRATE   = 16'h3001;
	localparam logic [7:0]  OD_SUBIDX_VALUE  = 8'h00;
	localparam logic [7:0]  NODE_ID_RESET    = 8'h1f;
	localparam logic [7:0]  BITRATE_RESET    = 8'h00;
	localparam logic [7:0]  NODE_SETTING_MAX = 8'h7e;
	localparam logic [7:0]  BR_CODE_MAX      = 8'h07;

	localparam logic [3:0]  BCD_DIGIT_MAX    = 4'h9;
	localparam logic [6:0]  BCD_TENS_WEIGHT  = 7'h0a;
	localparam logic [6:0]  ADDR_MAX_VALID   = 7'h59;
	localparam logic [6:0]  ADDR_LEGACY      = 7'h61;
	localparam logic [6:0]  ADDR_PROTO_V3    = 7'h62;
	localparam logic [6:0]  ADDR_PROTO_V4    = 7'h63;
	localparam logic [7:0]  NODE_ID_OFFSET   = 8'h01;
	localparam logic [3:0]  BR_SW_RESERVED   = 4'h8;
	localparam logic [3:0]  BR_SW_SOFTWARE   = 4'h9;
	localparam logic [10:0] BOOTUP_COB_BASE  = 11'h700;
	localparam logic [1:0]  SETTLE_CYCLES    = 2'h3;

	localparam logic [10:0] BITRATE_KBPS [8] = '{11'h014, 11'h032, 11'h064, 11'h07d,
	                                             11'h0fa, 11'h1f4, 11'h320, 11'h3e8};

	typedef enum logic [1:0] {
		CNC_NMT_INIT    = 2'b00,
		CNC_NMT_PREOP   = 2'b01,
		CNC_NMT_OPER    = 2'b10,
		CNC_NMT_STOPPED = 2'b11
	} cnc_nmt_t;

	typedef enum logic [1:0] {
		CNC_PROTO_DEFAULT = 2'b00,
		CNC_PROTO_LEGACY  = 2'b01,
		CNC_PROTO_V3      = 2'b10,
		CNC_PROTO_V4      = 2'b11
	} cnc_proto_t;

	typedef enum logic [2:0] {
		CNC_PAT_OFF     = 3'b000,
		CNC_PAT_ON      = 3'b001,
		CNC_PAT_FLICKER = 3'b010,
		CNC_PAT_BLINK   = 3'b011,
		CNC_PAT_FLASH1  = 3'b100,
		CNC_PAT_FLASH2  = 3'b101,
		CNC_PAT_FLASH3  = 3'b110,
		CNC_PAT_FLASH4  = 3'b111
	} cnc_pat_t;

	typedef struct packed {
		cnc_nmt_t nmt_state;
		logic     autobaud_lss;
		logic     fw_download;
		logic     warn_limit;
		logic     guard_event;
		logic     sync_timeout;
		logic     pdo_timeout;
		logic     bus_off;
	} cnc_net_status_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [7:0]  subindex;
		logic [7:0]  wdata;
	} cnc_od_req_t;

	typedef struct packed {
		logic       ack;
		logic       err;
		logic [7:0] rdata;
	} cnc_od_rsp_t;

endpackage

// ==== cnc_node_cfg_props.sv ====
// Checker for the node configuration block: decode, object access, boot-up, indicators.
// Sees only the block's ports; bound into every instance of the block.
`timescale 1ns/1ps
module cnc_node_cfg_props (
	input wire logic                     CLK_SYS,
	input wire logic                     SYS_RST,
	input wire logic [3:0]               UNITS_ADDRESS_SWITCH,
	input wire logic [3:0]               TENS_ADDRESS_SWITCH,
	input wire logic [3:0]               BITRATE_SELECTOR_SWITCH,
	input wire cnc_pkg::cnc_net_status_t NET_STATUS,
	input wire cnc_pkg::cnc_od_req_t     OD_REQ,
	input wire cnc_pkg::cnc_od_rsp_t     OD_RSP,
	input wire logic [6:0]               NODE_ID,
	input wire logic [2:0]               BITRATE_CODE,
	input wire cnc_pkg::cnc_proto_t      PROTO_MODE,
	input wire logic                     CONFIG_ERROR,
	input wire logic                     SOFTWARE_CONFIG,
	input wire logic                     BOOTUP_REQ,
	input wire logic [10:0]              BOOTUP_COB_ID,
	input wire logic                     RUN_INDICATOR,
	input wire logic                     ERROR_INDICATOR
);
	logic [2:0] up;
	logic       ok;
	logic [6:0] addr;
	logic [3:0] sw;
	assign sw = BITRATE_SELECTOR_SWITCH;
	assign ok = UNITS_ADDRESS_SWITCH < 4'ha && TENS_ADDRESS_SWITCH < 4'ha;
	assign addr = 7'(TENS_ADDRESS_SWITCH) * 7'h0a + 7'(UNITS_ADDRESS_SWITCH);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	// Keeps decode checks off until the synchroniser and decode stages have filled
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	end
	sequence sw_steady;
		(up > 3'h3 && $stable(UNITS_ADDRESS_SWITCH) && $stable(TENS_ADDRESS_SWITCH)
			&& $stable(sw)) [*4];
	endsequence
	sequence net_steady;
		(up > 3'h3 && $stable(NET_STATUS) && $stable(CONFIG_ERROR)) [*6];
	endsequence
	a_node_plus_one: assert property (sw_steady ##0 (ok && addr < 7'h5a && sw < 4'h8)
		|-> NODE_ID == addr + 7'h01 && !CONFIG_ERROR) else $error("node number wrong");
	a_reserved_addr: assert property (sw_steady ##0 (ok && addr inside {[7'h5a:7'h60]}
		&& sw != 4'h9) |-> CONFIG_ERROR) else $error("reserved address accepted");
	a_special_code: assert property (sw_steady ##0 (ok && addr > 7'h60 && sw != 4'h9)
		|-> PROTO_MODE == 2'(addr - 7'h60)) else $error("special code mode wrong");
	a_rate_decode: assert property (sw_steady ##0 sw < 4'h8
		|-> BITRATE_CODE == sw[2:0]) else $error("bit rate code wrong");
	a_rate_reserved: assert property (sw_steady ##0 sw == 4'h8 |-> CONFIG_ERROR)
		else $error("reserved rate accepted");
	a_soft_select: assert property (sw_steady ##0 sw == 4'h9 |-> SOFTWARE_CONFIG)
		else $error("software setting not selected");
	a_od_answer: assert property (OD_REQ.valid |=> OD_RSP.ack)
		else $error("object access not answered");
	a_od_refuse: assert property (OD_REQ.valid && (OD_REQ.subindex != 8'h00
		|| !(OD_REQ.index inside {16'h3000, 16'h3001})) |=> OD_RSP.err && OD_RSP.rdata == 8'h00)
		else $error("bad index not refused");
	a_boot_cob_id: assert property (BOOTUP_REQ
		|-> BOOTUP_COB_ID == 11'h700 + 11'(NODE_ID)) else $error("boot-up identifier wrong");
	a_run_oper_on: assert property (net_steady ##0 (NET_STATUS.nmt_state ==
		cnc_pkg::CNC_NMT_OPER && !NET_STATUS.autobaud_lss && !NET_STATUS.fw_download)
		|-> RUN_INDICATOR) else $error("run indicator not on");
	a_flicker_pair: assert property (net_steady ##0 NET_STATUS.autobaud_lss
		|-> RUN_INDICATOR != ERROR_INDICATOR) else $error("flicker not opposed");
	a_err_idle_off: assert property (net_steady ##0 (NET_STATUS[6:0] == 7'h00
		&& !CONFIG_ERROR) |-> !ERROR_INDICATOR) else $error("error indicator lit");
	a_busoff_on: assert property (net_steady ##0 (NET_STATUS.bus_off
		&& !NET_STATUS.autobaud_lss) |-> ERROR_INDICATOR) else $error("bus-off not shown");
endmodule

bind cnc_node_cfg cnc_node_cfg_props i_cnc_node_cfg_props (.CLK_SYS, .SYS_RST,
	.UNITS_ADDRESS_SWITCH, .TENS_ADDRESS_SWITCH, .BITRATE_SELECTOR_SWITCH, .NET_STATUS,
	.OD_REQ, .OD_RSP, .NODE_ID, .BITRATE_CODE, .PROTO_MODE, .CONFIG_ERROR,
	.SOFTWARE_CONFIG, .BOOTUP_REQ, .BOOTUP_COB_ID, .RUN_INDICATOR, .ERROR_INDICATOR);

// ==== cnc_cfg_master.sv ====
// Configuration master model: object reads and writes over the strobe port.
// Called from the testbench just after a clock edge; holds the request one edge.
`timescale 1ns/1ps
module cnc_cfg_master (
	input  wire logic                 clk,
	input  wire cnc_pkg::cnc_od_rsp_t od_rsp,
	output cnc_pkg::cnc_od_req_t      od_req
);
	initial od_req = '0;
	// Master sets node and rate through the object entries
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
	                      output cnc_pkg::cnc_od_rsp_t rsp);
		od_req = '{1'b1, wr, idx, 8'h00, wd};
		@(posedge clk);
		#1;
		rsp = od_rsp;
		// Released fields turn over so stale values cannot be mistaken for a request
		od_req = '{1'b0, ~wr, ~idx, 8'hff, ~wd};
		@(posedge clk);
		#1;
	endtask
endmodule

// ==== can_node_config_and_status_leds_tb_top.sv ====
// Testbench for the node configuration block: switches, object entries, boot-up, indicators.
// Indicator tick shortened to a few cycles; the master model drives object access.
`timescale 1ns/1ps
module can_node_config_and_status_leds_tb_top;
	localparam int TK = 4;
	localparam logic [10:0] KB [8] = '{11'h014, 11'h032, 11'h064, 11'h07d,
	                                   11'h0fa, 11'h1f4, 11'h320, 11'h3e8};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] units = 4'h2;
	logic [3:0] tens = 4'h1;
	logic [3:0] br_sw = 4'h3;
	cnc_pkg::cnc_net_status_t net = '0;
	cnc_pkg::cnc_od_req_t od_req;
	cnc_pkg::cnc_od_rsp_t od_rsp;
	cnc_pkg::cnc_proto_t proto;
	logic [6:0] node_id;
	logic [2:0] br_code;
	logic [10:0] kbps;
	logic [10:0] boot_id;
	logic cfg_err, sw_cfg, boot, run_led, error_indicator;
	int err_total = 0;
	int cmp_count = 0;
	always #2 clk = ~clk;
	cnc_node_cfg #(.TICK_CYCLES(TK)) i_cnc_node_cfg (.CLK_SYS(clk), .SYS_RST(rst),
		.UNITS_ADDRESS_SWITCH(units), .TENS_ADDRESS_SWITCH(tens),
		.BITRATE_SELECTOR_SWITCH(br_sw), .NET_STATUS(net), .OD_REQ(od_req), .OD_RSP(od_rsp),
		.NODE_ID(node_id), .BITRATE_CODE(br_code), .BITRATE_KBPS(kbps), .PROTO_MODE(proto),
		.CONFIG_ERROR(cfg_err), .SOFTWARE_CONFIG(sw_cfg), .BOOTUP_REQ(boot),
		.BOOTUP_COB_ID(boot_id), .RUN_INDICATOR(run_led), .ERROR_INDICATOR(error_indicator));
	cnc_cfg_master i_cnc_cfg_master (.clk(clk), .od_rsp(od_rsp), .od_req(od_req));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
	                  input logic [7:0] rd, input logic e);
		cnc_pkg::cnc_od_rsp_t r;
		i_cnc_cfg_master.access(wr, idx, wd, r);
		chk(r, {1'b1, e, rd});
	endtask
	task automatic t_boot;
		for (int i = 0; i < 20 && boot !== 1'b1; i++)
			cyc(1);
		chk({boot, boot_id, node_id}, {1'b1, 11'h70d, 7'h0d});
		cyc(1);
		chk(boot, 1'b0);
		od(1'b0, 16'h3000, 8'h00, 8'h1f, 1'b0);
		od(1'b0, 16'h3001, 8'h00, 8'h00, 1'b0);
		$display("test boot done");
	endtask
	task automatic t_rates;
		for (int i = 0; i < 9; i++) begin
			br_sw = 4'(i);
			// Six cycles give the checker five steady samples of the switch
			cyc(6);
			chk({cfg_err, br_code}, {i == 8, i == 8 ? 3'h0 : 3'(i)});
			if (i < 8)
				chk(kbps, KB[i]);
		end
		$display("test rates done");
	endtask
	task automatic ad(input logic [3:0] t, input logic [3:0] u, input logic [6:0] n,
	                  input logic [1:0] p, input logic e);
		tens = t;
		units = u;
		cyc(6);
		chk({node_id, proto, cfg_err}, {n, p, e});
	endtask
	task automatic t_addr;
		br_sw = 4'h3;
		ad(4'h0, 4'h0, 7'h01, 2'h0, 1'b0);
		ad(4'h8, 4'h9, 7'h5a, 2'h0, 1'b0);
		ad(4'h9, 4'h0, 7'h20, 2'h0, 1'b1);
		ad(4'h9, 4'h7, 7'h20, 2'h1, 1'b0);
		ad(4'h9, 4'h8, 7'h20, 2'h2, 1'b0);
		ad(4'h9, 4'h9, 7'h20, 2'h3, 1'b0);
		ad(4'h1, 4'ha, 7'h20, 2'h0, 1'b1);
		ad(4'h1, 4'h2, 7'h0d, 2'h0, 1'b0);
		$display("test address done");
	endtask
	task automatic t_soft;
		br_sw = 4'h9;
		cyc(4);
		chk({sw_cfg, node_id, br_code, kbps}, {1'b1, 7'h20, 3'h0, 11'h014});
		od(1'b1, 16'h3000, 8'h7e, 8'h1f, 1'b0);
		chk(node_id, 7'h7f);
		od(1'b1, 16'h3000, 8'h00, 8'h7e, 1'b0);
		chk(node_id, 7'h01);
		od(1'b1, 16'h3001, 8'h07, 8'h00, 1'b0);
		chk({br_code, kbps}, {3'h7, 11'h3e8});
		od(1'b1, 16'h3002, 8'h55, 8'h00, 1'b1);
		od(1'b0, 16'h3001, 8'h00, 8'h07, 1'b0);
		od(1'b1, 16'h3000, 8'h1f, 8'h00, 1'b0);
		od(1'b1, 16'h3001, 8'h00, 8'h07, 1'b0);
		chk({node_id, br_code}, {7'h20, 3'h0});
		$display("test software done");
	endtask
	task automatic led(input logic [8:0] ns, input logic [3:0] sw, input logic sel,
	                   input int per, input int on);
		logic [31:0] n;
		net = ns;
		br_sw = sw;
		cyc(8);
		n = '0;
		repeat (per * TK) begin
			n = n + {31'h0, sel ? error_indicator : run_led};
			cyc(1);
		end
		chk(n, 32'(on * TK));
	endtask
	task automatic t_leds;
		led(9'h080, 4'h3, 1'b0, 8, 4);
		led(9'h180, 4'h3, 1'b0, 24, 4);
		led(9'h0a0, 4'h3, 1'b0, 40, 12);
		led(9'h100, 4'h3, 1'b0, 8, 8);
		led(9'h040, 4'h3, 1'b0, 2, 1);
		led(9'h040, 4'h3, 1'b1, 2, 1);
		led(9'h100, 4'h3, 1'b1, 8, 0);
		led(9'h100, 4'h8, 1'b1, 8, 4);
		led(9'h110, 4'h3, 1'b1, 24, 4);
		led(9'h108, 4'h3, 1'b1, 32, 8);
		led(9'h104, 4'h3, 1'b1, 40, 12);
		led(9'h102, 4'h3, 1'b1, 48, 16);
		led(9'h103, 4'h3, 1'b1, 8, 8);
		$display("test indicators done");
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		t_boot();
		t_rates();
		t_addr();
		t_soft();
		t_leds();
		stop_test();
	end
	// The run needs about 1250 cycles; this leaves ample margin
	initial begin
		#100_000;
		err_total++;
		stop_test();
	end
endmodule
